// *** hdl/spi_port_pkg.sv ***
// Package for the SPI master/slave port: register map, field positions,
// reset values and the pin carrier struct.
// Assumes a 32-bit AXI4-Lite bus with byte addresses.
package spi_port_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] DATA_OFFSET   = 4'h8;
	localparam logic [3:0] PINS_OFFSET   = 4'hC;

	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] PINS_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int IRQ_ENABLE_BIT    = 7;
	localparam int PORT_ENABLE_BIT   = 6;
	localparam int BIT_ORDER_BIT     = 5;
	localparam int MASTER_SELECT_BIT = 4;
	localparam int CLOCK_POL_BIT     = 3;
	localparam int CLOCK_PHASE_BIT   = 2;
	localparam int RATE_HI_BIT       = 1;
	localparam int RATE_LO_BIT       = 0;

	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int DONE_FLAG_BIT      = 7;
	localparam int COLLISION_FLAG_BIT = 6;
	localparam int DOUBLE_RATE_BIT    = 0;

	// ----------------------------------------------------------------
	// Pin direction fields (user-defined directions) and the select output level
	// ----------------------------------------------------------------
	localparam int PIN_MOSI_DIR = 0;
	localparam int PIN_MISO_DIR = 1;
	localparam int PIN_SCK_DIR  = 2;
	localparam int PIN_SEL_DIR  = 3;
	localparam int PIN_SEL_OUT  = 4;

	localparam int BYTE_BITS = 8;

	// Half SCK period in system clocks, index {double, hi, lo}
	localparam logic [6:0] HALF_DIV_000 = 7'd2;
	localparam logic [6:0] HALF_DIV_001 = 7'd8;
	localparam logic [6:0] HALF_DIV_010 = 7'd32;
	localparam logic [6:0] HALF_DIV_011 = 7'd64;
	localparam logic [6:0] HALF_DIV_100 = 7'd1;
	localparam logic [6:0] HALF_DIV_101 = 7'd4;
	localparam logic [6:0] HALF_DIV_110 = 7'd16;
	localparam logic [6:0] HALF_DIV_111 = 7'd32;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic mosi;
		logic miso;
		logic sck;
		logic sel;
	} spi_pins_s;

endpackage

// *** hdl/spi_master_slave_port.sv ***
// SPI master/slave port with control, status, data and pin-direction
// registers on an AXI4-Lite slave.
// Assumes pin inputs are asynchronous; pad wires are resolved outside.
//
// Functional notes
// - Slave deselected: passive, logic reset, byte dropped.
// - Slave selected: active, MISO driven if configured.
// - Master select output is plain output.
// - Master select input low forces slave mode.
// - Mastership loss sets transfer-done flag.
// - Interrupt needs enable, done flag, global enable.
// - No operation unless port enabled.
// - Bit order one shifts LSB first.
// - Master bit selects master or slave.
// - Polarity sets SCK idle level.
// - Phase picks sample and setup edges.
// - Master SCK divider from rate bits.
// - Done flag set at byte end.
// - Done cleared by vector or status-data sequence.
// - Data write during transfer sets collision.
// - Status read then data access clears flags.
// - Status bits five to one read zero.
// - Double rate halves master divider.
// - Data write starts; read returns receive buffer.
// - Shift and capture on opposite edges.
// - Master transfer is eight bits exactly.
// - Single transmit buffer, double receive buffer.
`timescale 1ns/1ps

module spi_master_slave_port
	import spi_port_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// AXI4-Lite slave
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Processor side
	input  wire logic              globalIrqEnable,
	input  wire logic              vectorTaken,
	output logic                   irqReq,
	// Pins
	input  wire spi_port_pkg::spi_pins_s pinIn,
	output spi_port_pkg::spi_pins_s      pinOut,
	output spi_port_pkg::spi_pins_s      pinOe
);
	import spi_port_pkg::*;

	typedef enum {IDLE, RUN} xfer_e;

	// ----------------------------------------------------------------
	// Registers and pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic       doneFlag_q;
	logic       collFlag_q;
	logic       dblRate_q;
	logic [4:0] pinCfg_q;
	logic [7:0] shift_q;
	logic [7:0] rxBuf_q;
	logic [2:0] bitCnt_q;
	logic       edgeHalf_q;
	logic [6:0] divCnt_q;
	logic       sckOut_q;
	logic       sampled_q;
	logic       statusArmed_q;
	xfer_e      state_q;
	spi_pins_s  sync1_q;
	spi_pins_s  sync2_q;
	logic       sckPrev_q;
	logic [7:0] rxShift_q;
	logic [1:0] sampPipe_q;
	logic [1:0] endPipe_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			sckPrev_q <= 1'b0;
		end else begin
			sync1_q   <= pinIn;
			sync2_q   <= sync1_q;
			sckPrev_q <= sync2_q.sck;
		end
	end

	logic enable;
	logic master;
	logic lsbFirst;
	logic clock_idle_polarity;
	logic clock_sample_phase;
	assign enable   = ctrl_q[PORT_ENABLE_BIT];
	assign master   = ctrl_q[MASTER_SELECT_BIT];
	assign lsbFirst = ctrl_q[BIT_ORDER_BIT];
	assign clock_idle_polarity     = ctrl_q[CLOCK_POL_BIT];
	assign clock_sample_phase     = ctrl_q[CLOCK_PHASE_BIT];

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic wrFire;
	logic rdFire;
	logic [3:0] wrAddr;
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready  = s_axi_awready;
	assign wrFire        = s_axi_awready;
	assign wrAddr        = s_axi_awaddr;
	assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
	assign rdFire        = s_axi_arready;

	logic wrLane0;
	assign wrLane0 = wrFire && s_axi_wstrb[0];
	logic wrCtrl;
	logic wrStatus;
	logic wrData;
	logic wrPins;
	logic rdStatus;
	logic rdData;
	assign wrCtrl   = wrLane0 && wrAddr == CTRL_OFFSET;
	assign wrStatus = wrLane0 && wrAddr == STATUS_OFFSET;
	assign wrData   = wrLane0 && wrAddr == DATA_OFFSET;
	assign wrPins   = wrLane0 && wrAddr == PINS_OFFSET;
	assign rdStatus = rdFire && s_axi_araddr == STATUS_OFFSET;
	assign rdData   = rdFire && s_axi_araddr == DATA_OFFSET;

	function automatic logic mapped(input logic [3:0] a);
		return a == CTRL_OFFSET || a == STATUS_OFFSET
			|| a == DATA_OFFSET || a == PINS_OFFSET;
	endfunction

	// ----------------------------------------------------------------
	// Slave select and mode decisions
	// ----------------------------------------------------------------
	logic selLow;
	logic selIsInput;
	logic modeFault;
	logic slaveActive;
	assign selLow      = !sync2_q.sel;
	assign selIsInput  = !pinCfg_q[PIN_SEL_DIR];
	// Output-configured select pin is ignored for the mode fault
	assign modeFault   = enable && master && selIsInput && selLow;
	assign slaveActive = enable && !master && selLow;

	// Slave SCK edges; leading edge rises when polarity is zero
	logic sckRise;
	logic sckFall;
	logic slvLead;
	logic slvTrail;
	assign sckRise  = sync2_q.sck && !sckPrev_q;
	assign sckFall  = !sync2_q.sck && sckPrev_q;
	assign slvLead  = slaveActive && (clock_idle_polarity ? sckFall : sckRise);
	assign slvTrail = slaveActive && (clock_idle_polarity ? sckRise : sckFall);

	// ----------------------------------------------------------------
	// Master clock generator
	// ----------------------------------------------------------------
	function automatic logic [6:0] halfDiv(input logic [2:0] sel);
		case (sel)
			3'b000:  return HALF_DIV_000;
			3'b001:  return HALF_DIV_001;
			3'b010:  return HALF_DIV_010;
			3'b011:  return HALF_DIV_011;
			3'b100:  return HALF_DIV_100;
			3'b101:  return HALF_DIV_101;
			3'b110:  return HALF_DIV_110;
			default: return HALF_DIV_111;
		endcase
	endfunction

	logic [6:0] halfLen;
	logic       mstTick;
	logic       mstRun;
	assign halfLen = halfDiv({dblRate_q, ctrl_q[RATE_HI_BIT], ctrl_q[RATE_LO_BIT]});
	assign mstRun  = state_q == RUN && master && enable;
	assign mstTick = mstRun && divCnt_q == halfLen - 7'd1;

	logic lead;
	logic trail;
	assign lead  = mstRun ? (mstTick && !edgeHalf_q) : slvLead;
	assign trail = mstRun ? (mstTick && edgeHalf_q) : slvTrail;

	logic sampleEdge;
	logic setupEdge;
	assign sampleEdge = clock_sample_phase ? trail : lead;
	assign setupEdge  = clock_sample_phase ? lead : trail;

	// Master reads the synchronised MISO two clocks after its sample edge,
	// so the pin synchroniser lag never picks up the next bit
	logic capBit;
	logic serOut;
	assign capBit = master ? sync2_q.miso : sync2_q.mosi;
	assign serOut = lsbFirst ? shift_q[0] : shift_q[7];

	logic lastBit;
	logic lastEdge;
	logic byteDone;
	logic capture;
	assign lastBit  = bitCnt_q == 3'(BYTE_BITS - 1);
	// Byte ends at the trailing edge of the eighth bit
	assign lastEdge = trail && lastBit && (clock_sample_phase || sampled_q);
	assign byteDone = master ? endPipe_q[1] : lastEdge;
	assign capture  = master ? sampPipe_q[1] : sampleEdge;

	function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b,
		input logic lsb);
		return lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	logic busy;
	assign busy = state_q == RUN || sampPipe_q != 2'b00 || endPipe_q != 2'b00
		|| (slaveActive && (bitCnt_q != 3'd0 || sampled_q));

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q    <= IDLE;
			divCnt_q   <= '0;
			edgeHalf_q <= 1'b0;
			sckOut_q   <= 1'b0;
		end else if (!enable || modeFault || !master) begin
			state_q    <= IDLE;
			divCnt_q   <= '0;
			edgeHalf_q <= 1'b0;
			sckOut_q   <= clock_idle_polarity;
		end else if (state_q == IDLE) begin
			sckOut_q   <= clock_idle_polarity;
			divCnt_q   <= '0;
			edgeHalf_q <= 1'b0;
			if (wrData) begin
				state_q <= RUN;
			end
		end else begin
			divCnt_q <= mstTick ? 7'd0 : divCnt_q + 7'd1;
			if (mstTick) begin
				edgeHalf_q <= !edgeHalf_q;
				sckOut_q   <= !sckOut_q;
				if (lastEdge) begin
					state_q  <= IDLE;
					sckOut_q <= clock_idle_polarity;
				end
			end
		end
	end

	// Receive shifter and buffer, with the master's delayed capture
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rxShift_q  <= '0;
			rxBuf_q    <= '0;
			sampPipe_q <= '0;
			endPipe_q  <= '0;
		end else begin
			if (!enable || modeFault) begin
				sampPipe_q <= '0;
				endPipe_q  <= '0;
			end else begin
				sampPipe_q <= {sampPipe_q[0], mstRun && sampleEdge};
				endPipe_q  <= {endPipe_q[0], mstRun && lastEdge};
			end
			if (capture) begin
				rxShift_q <= shiftIn(rxShift_q, capBit, lsbFirst);
			end
			if (byteDone) begin
				rxBuf_q <= capture ? shiftIn(rxShift_q, capBit, lsbFirst) : rxShift_q;
			end
		end
	end

	// Transmit shifter and bit counter; output moves only on setup edges
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			shift_q   <= '0;
			bitCnt_q  <= '0;
			sampled_q <= 1'b0;
		end else if (!enable || (!master && !selLow)) begin
			bitCnt_q  <= '0;
			sampled_q <= 1'b0;
			if (wrData && enable) begin
				shift_q <= s_axi_wdata[7:0];
			end
		end else if (wrData && !busy) begin
			shift_q   <= s_axi_wdata[7:0];
			bitCnt_q  <= '0;
			sampled_q <= 1'b0;
		end else begin
			if (sampleEdge) begin
				sampled_q <= 1'b1;
			end
			if (setupEdge && sampled_q) begin
				sampled_q <= 1'b0;
				bitCnt_q  <= bitCnt_q + 3'd1;
				shift_q   <= lsbFirst ? {1'b0, shift_q[7:1]} : {shift_q[6:0], 1'b0};
			end
			if (lastEdge) begin
				sampled_q <= 1'b0;
				bitCnt_q  <= '0;
			end
		end
	end

	// Serial output holds the bit under the sampling cursor
	logic misoBit;
	logic mosiBit;
	assign misoBit = serOut;
	assign mosiBit = serOut;

	// ----------------------------------------------------------------
	// Registers written by software, flags set by hardware
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RESET;
		end else if (wrCtrl) begin
			ctrl_q <= s_axi_wdata[7:0];
		end else if (modeFault) begin
			ctrl_q[MASTER_SELECT_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			dblRate_q <= STATUS_RESET[DOUBLE_RATE_BIT];
			pinCfg_q  <= PINS_RESET[4:0];
		end else begin
			if (wrStatus) begin
				dblRate_q <= s_axi_wdata[DOUBLE_RATE_BIT];
			end
			if (wrPins) begin
				pinCfg_q <= s_axi_wdata[4:0];
			end
		end
	end

	// Armed by a status read that saw a flag; any data access then clears
	logic dataAccess;
	logic seqClear;
	assign dataAccess = wrData || rdData;
	assign seqClear   = dataAccess && statusArmed_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			statusArmed_q <= 1'b0;
		end else if (rdStatus) begin
			statusArmed_q <= doneFlag_q || collFlag_q;
		end else if (dataAccess) begin
			statusArmed_q <= 1'b0;
		end
	end

	// Set wins over clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			doneFlag_q <= STATUS_RESET[DONE_FLAG_BIT];
			collFlag_q <= STATUS_RESET[COLLISION_FLAG_BIT];
		end else begin
			if (byteDone || modeFault) begin
				doneFlag_q <= 1'b1;
			end else if (seqClear || vectorTaken) begin
				doneFlag_q <= 1'b0;
			end
			if (wrData && busy) begin
				collFlag_q <= 1'b1;
			end else if (seqClear) begin
				collFlag_q <= 1'b0;
			end
		end
	end

	assign irqReq = ctrl_q[IRQ_ENABLE_BIT] && doneFlag_q && globalIrqEnable;

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	logic mstPins;
	assign mstPins = enable && master;

	always_comb begin
		pinOut      = '0;
		pinOe       = '0;
		pinOut.mosi = mosiBit;
		pinOut.miso = misoBit;
		pinOut.sck  = sckOut_q;
		pinOut.sel  = pinCfg_q[PIN_SEL_OUT];
		pinOe.sel   = pinCfg_q[PIN_SEL_DIR] && (!enable || master);
		if (mstPins) begin
			pinOe.mosi = pinCfg_q[PIN_MOSI_DIR];
			pinOe.sck  = pinCfg_q[PIN_SCK_DIR];
		end else if (slaveActive) begin
			pinOe.miso = pinCfg_q[PIN_MISO_DIR];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite responses
	// ----------------------------------------------------------------
	logic [7:0] rdByte;
	always_comb begin
		case (s_axi_araddr)
			CTRL_OFFSET:   rdByte = ctrl_q;
			STATUS_OFFSET: rdByte = {doneFlag_q, collFlag_q, 5'b00000, dblRate_q};
			DATA_OFFSET:   rdByte = rxBuf_q;
			PINS_OFFSET:   rdByte = {3'b000, pinCfg_q};
			default:       rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rdFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rdByte};
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// *** sim/spi_port_chk.sv ***
// Bus, interrupt and pin assertions for the SPI port.
// Assumes it is bound into the port and sees its ports only.
`timescale 1ns/1ps
module spi_port_chk
	import spi_port_pkg::*;
(
	input wire logic                    sys_clk,
	input wire logic                    rst_b,
	input wire logic                    s_axi_awready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic                    s_axi_arready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [1:0]              s_axi_rresp,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic                    globalIrqEnable,
	input wire logic                    irqReq,
	input wire spi_port_pkg::spi_pins_s pinIn,
	input wire spi_port_pkg::spi_pins_s pinOe
);
	import spi_port_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	write_answer_a: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("no write answer");
	read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	pending_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answer pends");
	irq_gate_a: assert property (!globalIrqEnable |-> !irqReq)
		else $error("interrupt without global enable");
	slave_quiet_a: assert property (pinIn.sel [*4] |-> !pinOe.miso)
		else $error("miso driven while deselected");
	mode_fault_a: assert property (
		!pinOe.sel && $fell(pinIn.sel) ##1 !pinIn.sel [*5] |-> !pinOe.mosi && !pinOe.sck)
		else $error("master kept driving after select loss");

	cover property ($rose(irqReq));
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property (!pinOe.sel && $fell(pinIn.sel));
endmodule

bind spi_master_slave_port spi_port_chk spi_port_chk_inst (.sys_clk, .rst_b,
	.s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .globalIrqEnable,
	.irqReq, .pinIn, .pinOe);

// *** sim/spi_far_end.sv ***
// Behavioural SPI slave facing the port.
// Assumes the bench sets mode and bit order before each frame.
`timescale 1ns/1ps
module spi_far_end (
	input wire logic       sck,
	input wire logic       mosi,
	input wire logic       selN,
	input wire logic       clock_idle_polarity,
	input wire logic       clock_sample_phase,
	input wire logic       lsbFirst,
	input wire logic [7:0] txByte,
	output logic           miso,
	output logic [7:0]     rxByte
);
	logic       bitQ = 1'b0;
	logic [2:0] idx;
	// Released line shows the inverse, so a stale level never reads as data
	assign miso = selN ? ~bitQ : bitQ;
	always @(negedge selN) begin
		idx = 3'h0;
		bitQ = lsbFirst ? txByte[0] : txByte[7];
	end
	always @(sck) begin
		if (!selN && ((sck != clock_idle_polarity) ^ clock_sample_phase)) begin
			rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
			idx = idx + 3'h1;
		end else if (!selN) begin
			bitQ = txByte[lsbFirst ? idx : 3'h7 - idx];
		end
	end
endmodule

// *** sim/spi_master_slave_port_tb_top.sv ***
// Self-checking bench for the SPI port, master side traffic.
// Assumes the far-end model and the checker bind are compiled.
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		numChecks++; \
		if ((g) !== (e)) begin \
			errors++; \
			$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module spi_master_slave_port_tb_top;
	import spi_port_pkg::*;
	logic        sys_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        globalIrqEnable = 0, vectorTaken = 0, selN = 1, clock_idle_polarity = 0, clock_sample_phase = 0;
	logic        lsb = 0, sckQ = 0, farMiso, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, irqReq;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]  farTx = 8'h00, farRx, rd8, st;
	spi_pins_s   pinIn, pinOut, pinOe;
	int          errors = 0, numChecks = 0, tog = 0, gap = 0, lastGap = 0, t0, k;
	int          divTab[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

	assign pinIn = '{mosi: pinOe.mosi ? pinOut.mosi : ~pinOut.mosi,
		miso: pinOe.miso ? pinOut.miso : farMiso,
		sck: pinOe.sck ? pinOut.sck : 1'b0, sel: pinOe.sel ? pinOut.sel : selN};

	spi_master_slave_port spi_master_slave_port_inst (.*);
	spi_far_end spi_far_end_inst (.sck(pinIn.sck), .mosi(pinIn.mosi), .selN(pinIn.sel),
		.clock_idle_polarity, .clock_sample_phase, .lsbFirst(lsb), .txByte(farTx), .miso(farMiso), .rxByte(farRx));

	always #5 sys_clk = ~sys_clk;
	// Counts SCK edges and the spacing of the last two
	always @(posedge sys_clk) begin
		sckQ <= pinOut.sck;
		gap <= gap + 1;
		if (pinOut.sck !== sckQ) begin
			tog <= tog + 1;
			lastGap <= gap;
			gap <= 1;
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic waitHi(ref logic s);
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (s !== 1'b1 && k < 99);
		if (k >= 99) begin
			errors++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		waitHi(s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		waitHi(s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		waitHi(s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		waitHi(s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd8 = s_axi_rdata[7:0];
		rsp = s_axi_rresp;
	endtask

	// Polling the status arms the flag clear, as software would
	task automatic waitDone();
		int n;
		n = 0;
		do begin
			rd(STATUS_OFFSET);
			n++;
		end while (rd8[DONE_FLAG_BIT] !== 1'b1 && n < 999);
		st = rd8;
		if (n >= 999) begin
			errors++;
			wrap_up();
		end
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(CTRL_OFFSET);
		`CHK(rd8, CTRL_RESET)
		rd(STATUS_OFFSET);
		`CHK(rd8, STATUS_RESET)
		rd(PINS_OFFSET);
		`CHK(rd8, PINS_RESET)
		wr(STATUS_OFFSET, 8'hFF);
		rd(STATUS_OFFSET);
		`CHK(rd8, 8'h01)
		rd(4'h2);
		`CHK(rsp, RESP_SLVERR)
		$display("test registers done");
		wr(PINS_OFFSET, 8'h1D);
		wr(CTRL_OFFSET, 8'h10);
		t0 = tog;
		wr(DATA_OFFSET, 8'h5A);
		repeat (40) @(posedge sys_clk);
		`CHK(tog - t0, 0)
		$display("test disabled done");
		for (int i = 0; i < 8; i++) begin
			{lsb, clock_idle_polarity, clock_sample_phase} = 3'(i);
			farTx = 8'hE6 - 8'(i);
			wr(STATUS_OFFSET, {7'h0, lsb});
			wr(CTRL_OFFSET, {2'b01, lsb, 1'b1, clock_idle_polarity, clock_sample_phase, clock_idle_polarity, clock_sample_phase});
			wr(PINS_OFFSET, 8'h0D);
			t0 = tog;
			wr(DATA_OFFSET, 8'h13 + 8'(i));
			waitDone();
			`CHK(tog - t0, 16)
			`CHK(lastGap, divTab[i] / 2)
			`CHK(pinOut.sck, clock_idle_polarity)
			rd(DATA_OFFSET);
			`CHK(rd8, farTx)
			`CHK(farRx, 8'h13 + 8'(i))
			rd(STATUS_OFFSET);
			`CHK(rd8, {7'h0, lsb})
			wr(PINS_OFFSET, 8'h1D);
		end
		$display("test modes and rates done");
		wr(DATA_OFFSET, 8'h42);
		wr(DATA_OFFSET, 8'h24);
		waitDone();
		`CHK(st, 8'hC1)
		rd(DATA_OFFSET);
		rd(STATUS_OFFSET);
		`CHK(rd8, 8'h01)
		$display("test collision done");
		wr(STATUS_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'hD0);
		wr(DATA_OFFSET, 8'h7E);
		waitDone();
		`CHK(irqReq, 1'b0)
		globalIrqEnable <= 1'b1;
		@(posedge sys_clk);
		`CHK(irqReq, 1'b1)
		vectorTaken <= 1'b1;
		@(posedge sys_clk);
		vectorTaken <= 1'b0;
		@(posedge sys_clk);
		`CHK(irqReq, 1'b0)
		$display("test interrupt done");
		wr(PINS_OFFSET, 8'h07);
		selN <= 1'b0;
		repeat (8) @(posedge sys_clk);
		`CHK(irqReq, 1'b1)
		`CHK(pinOe.mosi, 1'b0)
		`CHK(pinOe.miso, 1'b1)
		rd(CTRL_OFFSET);
		`CHK(rd8, 8'hC0)
		selN <= 1'b1;
		repeat (8) @(posedge sys_clk);
		`CHK(pinOe.miso, 1'b0)
		wr(CTRL_OFFSET, 8'hD0);
		rd(CTRL_OFFSET);
		`CHK(rd8, 8'hD0)
		$display("test select loss done");
		wrap_up();
	end
endmodule
